// [logic/aasb_core.sv]
/*
  Add-with-carry, accumulator add, arithmetic right shift and branch slice of a core.
  Assumes the decoder presents operands already read and honours o_ready before issuing.
  Word results go out as one registered write-back; accumulators are held here, working registers live outside.
*/
`include "aasb_regs.svh"

module aasb_core (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input aasb_pkg::aasb_op_s i_op,
  output logic o_ready,
  output aasb_pkg::aasb_wb_s o_wb,
  output aasb_pkg::aasb_flags_s o_flags,
  output logic o_redirect,
  output logic [`AASB_DW-1:0] o_target,
  output logic [`AASB_ACC_W-1:0] o_acc_a,
  output logic [`AASB_ACC_W-1:0] o_acc_b
);

  // ==========================================================================
  // State
  localparam aasb_pkg::aasb_st_s ST_RESET = '0;

  aasb_pkg::aasb_st_s st_reg;
  aasb_pkg::aasb_st_s st_next;

  logic accept;
  logic [`AASB_CNT_W-1:0] shift_count;
  logic [`AASB_DW-1:0] shift_res;
  logic shift_carry;

  // ==========================================================================
  // Shifter
  // Single-step forms shift by one; the others take the count from operand or literal
  always_comb begin
    shift_count = `AASB_SHIFT_ONE;
    if (i_op.opc == aasb_pkg::OP_SHR_WCNT) begin
      shift_count = i_op.opnd_b[`AASB_CNT_W-1:0];
    end else if (i_op.opc == aasb_pkg::OP_SHR_FIVE_BIT_LITERAL) begin
      shift_count = i_op.lit[`AASB_FIVE_BIT_LITERAL_W-1:0];
    end
  end

  aasb_shift_unit u_shift (
    .i_value(i_op.opnd_a),
    .i_count(shift_count),
    .o_result(shift_res),
    .o_carry(shift_carry)
  );

  // ==========================================================================
  // Branch condition
  function automatic logic cond_met(input aasb_pkg::aasb_cond_e cond,
                                    input aasb_pkg::aasb_flags_s f);
    logic met;
    met = 1'b0;
    case (cond)
      aasb_pkg::COND_ALWAYS: met = 1'b1;
      aasb_pkg::COND_CARRY: met = f.carry;
      aasb_pkg::COND_NCARRY: met = !f.carry;
      aasb_pkg::COND_NEG: met = f.neg;
      aasb_pkg::COND_NNEG: met = !f.neg;
      aasb_pkg::COND_OVERFLOW: met = f.overflow_flag;
      aasb_pkg::COND_NOVERFLOW: met = !f.overflow_flag;
      aasb_pkg::COND_ZERO: met = f.zero;
      aasb_pkg::COND_NZERO: met = !f.zero;
      aasb_pkg::COND_GT: met = !f.zero && (f.neg == f.overflow_flag);
      aasb_pkg::COND_GE: met = (f.neg == f.overflow_flag);
      aasb_pkg::COND_LT: met = (f.neg != f.overflow_flag);
      aasb_pkg::COND_LE: met = f.zero || (f.neg != f.overflow_flag);
      aasb_pkg::COND_GTU: met = f.carry && !f.zero;
      aasb_pkg::COND_GEU: met = f.carry;
      aasb_pkg::COND_LTU: met = !f.carry;
      aasb_pkg::COND_LEU: met = !f.carry || f.zero;
      aasb_pkg::COND_ACC_A_OVF: met = f.acc_a_overflow_flag;
      aasb_pkg::COND_ACC_B_OVF: met = f.acc_b_overflow_flag;
      aasb_pkg::COND_ACC_A_SAT: met = f.acc_a_saturate_flag;
      aasb_pkg::COND_ACC_B_SAT: met = f.acc_b_saturate_flag;
      default: met = 1'b0;
    endcase
    return met;
  endfunction : cond_met

  // ==========================================================================
  // Issue handshake
  // A taken branch spends its second cycle as a bubble with no issue
  always_comb begin
    o_ready = (st_reg.state == aasb_pkg::ST_RUN);
    accept = i_op.valid && o_ready;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [`AASB_DW-1:0] add_b;
    logic [`AASB_DW:0] sum;
    logic [`AASB_NIB_W:0] nib;
    logic [`AASB_ACC_W-1:0] acc_old;
    logic [`AASB_ACC_W-1:0] acc_opnd;
    logic [`AASB_ACC_W:0] acc_sum;
    logic [`AASB_ACC_W-1:0] acc_res;
    logic signed [`AASB_SIGNED_FOUR_BIT_LITERAL_W-1:0] slit;
    logic acc_sat;
    logic acc_ovf;
    add_b = '0;
    sum = '0;
    nib = '0;
    acc_old = '0;
    acc_opnd = '0;
    acc_sum = '0;
    acc_res = '0;
    slit = '0;
    acc_sat = 1'b0;
    acc_ovf = 1'b0;

    // Flags and accumulators hold unless an operation names them
    st_next = st_reg;
    st_next.wb.valid = 1'b0;
    st_next.redirect = 1'b0;
    st_next.wb.to_file = i_op.to_file;
    st_next.wb.dest = i_op.dest;

    case (st_reg.state)
      aasb_pkg::ST_BUBBLE: begin
        st_next.state = aasb_pkg::ST_RUN;
      end
      default: begin
        st_next.state = aasb_pkg::ST_RUN;
      end
    endcase

    if (accept) begin
      case (i_op.opc)
        aasb_pkg::OP_ADD_WITH_CARRY_OP_FILE,
        aasb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL,
        aasb_pkg::OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL: begin
          // Second addend: default register, or zero-extended literal
          if (i_op.opc == aasb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL) begin
            add_b = {{(`AASB_DW-`AASB_TEN_BIT_LITERAL_W){1'b0}}, i_op.lit};
          end else if (i_op.opc == aasb_pkg::OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL) begin
            add_b = {{(`AASB_DW-`AASB_FIVE_BIT_LITERAL_W){1'b0}}, i_op.lit[`AASB_FIVE_BIT_LITERAL_W-1:0]};
          end else begin
            add_b = i_op.opnd_b;
          end
          sum = {1'b0, i_op.opnd_a} + {1'b0, add_b}
              + {{`AASB_DW{1'b0}}, st_reg.flags.carry};
          nib = {1'b0, i_op.opnd_a[`AASB_NIB_W-1:0]} + {1'b0, add_b[`AASB_NIB_W-1:0]}
              + {{`AASB_NIB_W{1'b0}}, st_reg.flags.carry};
          st_next.wb.valid = 1'b1;
          st_next.wb.data = sum[`AASB_DW-1:0];
          st_next.flags.carry = sum[`AASB_DW];
          st_next.flags.digit_carry_flag = nib[`AASB_NIB_W];
          st_next.flags.neg = sum[`AASB_SIGN_BIT];
          // Signed overflow: like-signed addends giving an unlike-signed sum
          st_next.flags.overflow_flag = (i_op.opnd_a[`AASB_SIGN_BIT] == add_b[`AASB_SIGN_BIT])
              && (sum[`AASB_SIGN_BIT] != i_op.opnd_a[`AASB_SIGN_BIT]);
          st_next.flags.zero = (sum[`AASB_DW-1:0] == '0);
        end
        aasb_pkg::OP_ADD_ACC: begin
          // Word sits in the middle of the accumulator, then the literal shifts it
          acc_old = i_op.acc_sel ? st_reg.acc_b : st_reg.acc_a;
          acc_opnd = {{`AASB_GUARD_W{i_op.opnd_a[`AASB_SIGN_BIT]}}, i_op.opnd_a,
                      {`AASB_DW{1'b0}}};
          slit = $signed(i_op.lit[`AASB_SIGNED_FOUR_BIT_LITERAL_W-1:0]);
          if (slit < 0) begin
            acc_opnd = acc_opnd << (-slit);
          end else begin
            acc_opnd = $unsigned($signed(acc_opnd) >>> slit);
          end
          acc_sum = {acc_old[`AASB_ACC_SIGN_BIT], acc_old}
              + {acc_opnd[`AASB_ACC_SIGN_BIT], acc_opnd};
          // Overflow past the top bit clamps; the saturation flag is sticky
          acc_sat = (acc_sum[`AASB_ACC_W] != acc_sum[`AASB_ACC_SIGN_BIT]);
          if (acc_sat) begin
            acc_res = acc_sum[`AASB_ACC_W] ? `AASB_ACC_MIN : `AASB_ACC_MAX;
          end else begin
            acc_res = acc_sum[`AASB_ACC_W-1:0];
          end
          // Guard bits not all copies of the word sign mean overflow into them
          acc_ovf = !((&acc_res[`AASB_ACC_SIGN_BIT:`AASB_ACC_WORD_MSB])
              || !(|acc_res[`AASB_ACC_SIGN_BIT:`AASB_ACC_WORD_MSB]));
          if (i_op.acc_sel) begin
            st_next.acc_b = acc_res;
            st_next.flags.acc_b_overflow_flag = acc_ovf;
            st_next.flags.acc_b_saturate_flag = st_reg.flags.acc_b_saturate_flag || acc_sat;
          end else begin
            st_next.acc_a = acc_res;
            st_next.flags.acc_a_overflow_flag = acc_ovf;
            st_next.flags.acc_a_saturate_flag = st_reg.flags.acc_a_saturate_flag || acc_sat;
          end
        end
        aasb_pkg::OP_SHR_FILE,
        aasb_pkg::OP_SHR_WORK: begin
          st_next.wb.valid = 1'b1;
          st_next.wb.data = shift_res;
          st_next.flags.carry = shift_carry;
          st_next.flags.neg = shift_res[`AASB_SIGN_BIT];
          st_next.flags.overflow_flag = 1'b0;
          st_next.flags.zero = (shift_res == '0);
        end
        aasb_pkg::OP_SHR_WCNT,
        aasb_pkg::OP_SHR_FIVE_BIT_LITERAL: begin
          // Carry and overflow are left alone by the multi-bit forms
          st_next.wb.valid = 1'b1;
          st_next.wb.data = shift_res;
          st_next.flags.neg = shift_res[`AASB_SIGN_BIT];
          st_next.flags.zero = (shift_res == '0);
        end
        aasb_pkg::OP_BRANCH: begin
          // Branches never touch flags; a taken one costs one extra cycle
          if (cond_met(i_op.cond, st_reg.flags)) begin
            st_next.redirect = 1'b1;
            st_next.target = i_op.target;
            st_next.state = aasb_pkg::ST_BUBBLE;
          end
        end
        default: begin
          st_next.wb.valid = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    o_wb = st_reg.wb;
    o_flags = st_reg.flags;
    o_redirect = st_reg.redirect;
    o_target = st_reg.target;
    o_acc_a = st_reg.acc_a;
    o_acc_b = st_reg.acc_b;
  end

endmodule : aasb_core

// [logic/aasb_regs.svh]
/*
  Named constants of the add, shift and branch datapath slice.
  Assumes it is included by bare name after aasb_pkg and before any module that uses it.
*/
`ifndef AASB_REGS_SVH
`define AASB_REGS_SVH

// ==========================================================================
// Widths
`define AASB_DW 16
`define AASB_CNT_W 5
`define AASB_NIB_W 4
`define AASB_ACC_W 40
`define AASB_GUARD_W 8
`define AASB_TEN_BIT_LITERAL_W 10
`define AASB_FIVE_BIT_LITERAL_W 5
`define AASB_SIGNED_FOUR_BIT_LITERAL_W 4

// ==========================================================================
// Field positions
`define AASB_SIGN_BIT 15
`define AASB_ACC_SIGN_BIT 39
`define AASB_ACC_WORD_MSB 31

// ==========================================================================
// Fixed values
`define AASB_SHIFT_ONE 5'h01
`define AASB_ACC_MAX 40'h7FFFFFFFFF
`define AASB_ACC_MIN 40'h8000000000

`endif

// [logic/aasb_pkg.sv]
/*
  Types shared by the datapath slice: operations, branch conditions, flags and state.
  Assumes the decoder fills one aasb_op_s per issued instruction word.
*/
package aasb_pkg;

  // ==========================================================================
  // Operations, branch conditions and core states
  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD_WITH_CARRY_OP_FILE,
    OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL,
    OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL,
    OP_ADD_ACC,
    OP_SHR_FILE,
    OP_SHR_WORK,
    OP_SHR_WCNT,
    OP_SHR_FIVE_BIT_LITERAL,
    OP_BRANCH
  } aasb_opc_e;

  typedef enum logic [4:0] {
    COND_ALWAYS,
    COND_CARRY, COND_NCARRY, COND_NEG, COND_NNEG,
    COND_OVERFLOW, COND_NOVERFLOW, COND_ZERO, COND_NZERO,
    COND_GT, COND_GE, COND_LT, COND_LE,
    COND_GTU, COND_GEU, COND_LTU, COND_LEU,
    COND_ACC_A_OVF, COND_ACC_B_OVF, COND_ACC_A_SAT, COND_ACC_B_SAT
  } aasb_cond_e;

  typedef enum logic {
    ST_RUN,
    ST_BUBBLE
  } aasb_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    aasb_opc_e opc;
    aasb_cond_e cond;
    logic [15:0] opnd_a;
    logic [15:0] opnd_b;
    logic [9:0] lit;
    logic to_file;
    logic [3:0] dest;
    logic acc_sel;
    logic [15:0] target;
  } aasb_op_s;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic neg;
    logic overflow_flag;
    logic zero;
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic acc_a_saturate_flag;
    logic acc_b_saturate_flag;
  } aasb_flags_s;

  typedef struct packed {
    logic valid;
    logic to_file;
    logic [3:0] dest;
    logic [15:0] data;
  } aasb_wb_s;

  typedef struct packed {
    aasb_state_e state;
    aasb_flags_s flags;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    aasb_wb_s wb;
    logic redirect;
    logic [15:0] target;
  } aasb_st_s;

endpackage : aasb_pkg

// [logic/aasb_shift_unit.sv]
/*
  Arithmetic right shifter for one data word, with the last bit shifted out.
  Assumes a purely combinational use inside the datapath slice.
*/
`include "aasb_regs.svh"

module aasb_shift_unit (
  input wire logic [`AASB_DW-1:0] i_value,
  input wire logic [`AASB_CNT_W-1:0] i_count,
  output logic [`AASB_DW-1:0] o_result,
  output logic o_carry
);

  // ==========================================================================
  // Shift datapath
  logic [`AASB_DW:0] ext_shifted;

  // One extra low bit lets the dropped bit fall out at position zero
  always_comb begin
    ext_shifted = $unsigned($signed({i_value, 1'b0}) >>> i_count);
    o_result = ext_shifted[`AASB_DW:1];
    o_carry = ext_shifted[0];
  end

endmodule : aasb_shift_unit

// [dv/aasb_core_props.sv]
/*
  Port checker for the add, shift and branch slice.
  Assumes it is bound onto every aasb_core and sees only its ports.
*/
module aasb_core_props (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input aasb_pkg::aasb_op_s i_op,
  input wire logic o_ready,
  input aasb_pkg::aasb_wb_s o_wb,
  input aasb_pkg::aasb_flags_s o_flags,
  input wire logic o_redirect,
  input wire logic [15:0] o_target,
  input wire logic [39:0] o_acc_a,
  input wire logic [39:0] o_acc_b
);
  // ==========================================================================
  // Helper terms
  logic issue;
  logic br;
  logic [15:0] tgt;
  logic [15:0] shr1;
  logic lsb;
  logic [2:0] keep3;
  logic [4:0] alu5;

  // Digests so that $past sees plain signals for the branch target and single-shift checks
  assign issue = i_op.valid && o_ready;
  assign br = issue && i_op.opc == aasb_pkg::OP_BRANCH;
  assign tgt = i_op.target;
  assign shr1 = {i_op.opnd_a[15], i_op.opnd_a[15:1]};
  assign lsb = i_op.opnd_a[0];
  assign keep3 = {o_flags.carry, o_flags.digit_carry_flag, o_flags.overflow_flag};
  assign alu5 = o_flags[8:4];

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // ==========================================================================
  // Properties
  property p_bubble;
    o_redirect |-> !o_ready ##1 o_ready;
  endproperty
  a_bubble: assert property (p_bubble) else $error("bubble after branch wrong");
  property p_uncond;
    br && i_op.cond == aasb_pkg::COND_ALWAYS |=> o_redirect && o_target == $past(tgt);
  endproperty
  a_uncond: assert property (p_uncond) else $error("branch always not taken");
  property p_br_flags;
    br |=> $stable(o_flags) && !o_wb.valid;
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("branch touched flags");
  property p_br_carry;
    br && i_op.cond == aasb_pkg::COND_CARRY |=> o_redirect == $past(o_flags.carry);
  endproperty
  a_br_carry: assert property (p_br_carry) else $error("carry branch wrong");
  property p_refuse;
    i_op.valid && !o_ready |=> !o_wb.valid && !o_redirect;
  endproperty
  a_refuse: assert property (p_refuse) else $error("op taken in bubble");
  property p_wb_dest;
    issue && i_op.opc inside {aasb_pkg::OP_ADD_WITH_CARRY_OP_FILE, aasb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL,
      aasb_pkg::OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL, aasb_pkg::OP_SHR_FILE, aasb_pkg::OP_SHR_WORK,
      aasb_pkg::OP_SHR_WCNT, aasb_pkg::OP_SHR_FIVE_BIT_LITERAL} |=> o_wb.valid && o_wb.dest == $past(i_op.dest);
  endproperty
  a_wb_dest: assert property (p_wb_dest) else $error("write-back missing");
  property p_shr_one;
    issue && i_op.opc == aasb_pkg::OP_SHR_WORK |=> o_wb.data == $past(shr1) && o_flags.carry == $past(lsb);
  endproperty
  a_shr_one: assert property (p_shr_one) else $error("single shift wrong");
  property p_cnt_keep;
    issue && i_op.opc inside {aasb_pkg::OP_SHR_WCNT, aasb_pkg::OP_SHR_FIVE_BIT_LITERAL} |=> $stable(keep3);
  endproperty
  a_cnt_keep: assert property (p_cnt_keep) else $error("counted shift touched flags");
  property p_acc_keep;
    issue && i_op.opc == aasb_pkg::OP_ADD_ACC |=> $stable(alu5);
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("accumulator add touched flags");
  property p_add_with_carry_op_nz;
    issue && i_op.opc inside {aasb_pkg::OP_ADD_WITH_CARRY_OP_FILE, aasb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL, aasb_pkg::OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL}
      |=> o_flags.zero == (o_wb.data == 16'h0000) && o_flags.neg == o_wb.data[15];
  endproperty
  a_add_with_carry_op_nz: assert property (p_add_with_carry_op_nz) else $error("add flags wrong");
endmodule : aasb_core_props

bind aasb_core aasb_core_props u_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_op(i_op), .o_ready(o_ready), .o_wb(o_wb), .o_flags(o_flags), .o_redirect(o_redirect),
  .o_target(o_target), .o_acc_a(o_acc_a), .o_acc_b(o_acc_b));

// [dv/tb_alu_add_shift_branch.sv]
/*
  Self-checking bench for aasb_core: adds, shifts, accumulator adds, branches.
  Assumes the checker file is compiled alongside and binds itself.
*/
module tb_alu_add_shift_branch;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_b;
  aasb_pkg::aasb_op_s op_in;
  logic ready;
  aasb_pkg::aasb_wb_s wb;
  aasb_pkg::aasb_flags_s flags;
  logic redirect;
  logic [15:0] target;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  aasb_pkg::aasb_flags_s ef;
  int failures = 0;
  int num_checks = 0;

  aasb_core uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_op(op_in), .o_ready(ready),
    .o_wb(wb), .o_flags(flags), .o_redirect(redirect), .o_target(target),
    .o_acc_a(acc_a), .o_acc_b(acc_b));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic aasb_pkg::aasb_op_s mk(input aasb_pkg::aasb_opc_e opc,
      input logic [15:0] a, input logic [15:0] b, input logic [9:0] lit);
    aasb_pkg::aasb_op_s op;
    op = '0;
    op.valid = 1'b1;
    op.opc = opc;
    op.opnd_a = a;
    op.opnd_b = b;
    op.lit = lit;
    op.dest = 4'hA;
    // The file shift writes its result back into the file register
    op.to_file = (opc == aasb_pkg::OP_SHR_FILE);
    return op;
  endfunction : mk

  // Inputs move at the falling edge only, so no race with the sampling edge
  task automatic send(input aasb_pkg::aasb_op_s op);
    op_in = op;
    @(negedge clk);
  endtask : send

  task automatic idle();
    op_in.valid = 1'b0;
    @(negedge clk);
  endtask : idle

  // One result word plus the five arithmetic flags
  task automatic alu(input aasb_pkg::aasb_op_s op, input logic [15:0] d, input logic [4:0] f5);
    send(op);
    ef = aasb_pkg::aasb_flags_s'({f5, ef[3:0]});
    chk(wb.valid, 1'b1);
    chk(wb.data, d);
    chk(wb.dest, 4'hA);
    chk(wb.to_file, op.to_file);
    chk(flags, ef);
  endtask : alu

  // Condition table indexed by the condition code, built from the expected flags
  function automatic logic taken(input aasb_pkg::aasb_cond_e c, input aasb_pkg::aasb_flags_s f);
    logic [20:0] v;
    v = {f.acc_b_saturate_flag, f.acc_a_saturate_flag, f.acc_b_overflow_flag,
      f.acc_a_overflow_flag, !f.carry || f.zero, !f.carry, f.carry, f.carry && !f.zero,
      f.zero || (f.neg != f.overflow_flag), f.neg != f.overflow_flag,
      f.neg == f.overflow_flag, !f.zero && (f.neg == f.overflow_flag), !f.zero, f.zero,
      !f.overflow_flag, f.overflow_flag, !f.neg, f.neg, !f.carry, f.carry, 1'b1};
    return v[c];
  endfunction : taken

  // ==========================================================================
  // Scenarios
  task automatic s_branches();
    aasb_pkg::aasb_op_s op;
    logic t;
    for (int k = 0; k < 21; k++) begin
      op = mk(aasb_pkg::OP_BRANCH, 16'h0000, 16'h0000, 10'h000);
      op.cond = aasb_pkg::aasb_cond_e'(k);
      op.target = 16'h4000 + 16'(k);
      t = taken(op.cond, ef);
      send(op);
      chk(redirect, t);
      chk(ready, !t);
      chk(flags, ef);
      if (t) chk(target, op.target);
      idle();
      chk(ready, 1'b1);
    end
  endtask : s_branches

  // Left shift by eight then saturate A high; right shift by one on B, then saturate B low
  task automatic s_acc();
    aasb_pkg::aasb_op_s op;
    op = mk(aasb_pkg::OP_ADD_ACC, 16'h7FFF, 16'h0000, 10'h3F8);
    send(op);
    chk(acc_a, 40'h7FFF000000);
    chk(flags, 9'h008);
    send(op);
    ef = aasb_pkg::aasb_flags_s'(9'h00A);
    chk(acc_a, 40'h7FFFFFFFFF);
    chk(flags, ef);
    op.acc_sel = 1'b1;
    op.opnd_a = 16'h8000;
    op.lit = 10'h001;
    send(op);
    chk(acc_b, 40'hFFC0000000);
    chk(flags, ef);
    // B flags set so that the B overflow and saturation branches get taken later
    op.lit = 10'h3F8;
    send(op);
    ef = aasb_pkg::aasb_flags_s'(9'h00F);
    chk(acc_b, 40'h8000000000);
    chk(flags, ef);
    chk(acc_a, 40'h7FFFFFFFFF);
  endtask : s_acc

  task automatic s_alu();
    alu(mk(aasb_pkg::OP_ADD_WITH_CARRY_OP_FILE, 16'h0001, 16'hFFFF, 10'h000), 16'h0000, 5'h19);
    s_branches();
    alu(mk(aasb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_LITERAL, 16'h7C00, 16'h0000, 10'h3FF), 16'h8000, 5'h0E);
    s_branches();
    alu(mk(aasb_pkg::OP_SHR_WCNT, 16'h8000, 16'hFFF3, 10'h000), 16'hFFFF, 5'h0E);
    alu(mk(aasb_pkg::OP_ADD_WITH_CARRY_OP_FIVE_BIT_LITERAL, 16'h0010, 16'h0000, 10'h3FF), 16'h002F, 5'h00);
    alu(mk(aasb_pkg::OP_SHR_FILE, 16'h8001, 16'h0000, 10'h000), 16'hC000, 5'h14);
    alu(mk(aasb_pkg::OP_SHR_WORK, 16'h0001, 16'h0000, 10'h000), 16'h0000, 5'h11);
    alu(mk(aasb_pkg::OP_SHR_FIVE_BIT_LITERAL, 16'h4000, 16'h0000, 10'h3EE), 16'h0001, 5'h10);
    s_branches();
  endtask : s_alu

  // An op offered in the bubble leaves no trace; the next ones run back to back
  task automatic s_refuse();
    aasb_pkg::aasb_op_s op;
    op = mk(aasb_pkg::OP_BRANCH, 16'h0000, 16'h0000, 10'h000);
    op.target = 16'h7E00;
    send(op);
    chk(target, 16'h7E00);
    send(mk(aasb_pkg::OP_ADD_WITH_CARRY_OP_FILE, 16'h0001, 16'h0001, 10'h000));
    chk(wb.valid, 1'b0);
    chk(flags, ef);
    alu(mk(aasb_pkg::OP_SHR_WORK, 16'h0002, 16'h0000, 10'h000), 16'h0001, 5'h00);
    alu(mk(aasb_pkg::OP_SHR_WORK, 16'h0003, 16'h0000, 10'h000), 16'h0001, 5'h10);
    idle();
    chk(wb.valid, 1'b0);
  endtask : s_refuse

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Main sequence and hang guard
  initial begin
    rst_b = 1'b0;
    op_in = '0;
    ef = '0;
    repeat (4) @(negedge clk);
    chk(ready, 1'b1);
    chk(flags, ef);
    rst_b = 1'b1;
    s_acc();
    s_alu();
    s_refuse();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : tb_alu_add_shift_branch
